// *** verilog/sepp_consts.vh ***
/*
 contents: opcodes, counts and timing constants of the protected serial eeprom.
 assumes: included by the eeprom core only; its output buffer does not include it.
*/
`ifndef SEPP_CONSTS_VH
`define SEPP_CONSTS_VH
`define SEPP_OP_EXT 2'h0
`define SEPP_OP_WRITE 2'h1
`define SEPP_OP_READ 2'h2
`define SEPP_OP_CLEAR 2'h3
`define SEPP_EXT_DIS 2'h0
`define SEPP_EXT_WALL 2'h1
`define SEPP_EXT_EN 2'h3
`define SEPP_HDR_BITS 5'h0b
`define SEPP_DATA_BITS 5'h10
`define SEPP_PTR_BITS 5'h08
`define SEPP_PTR_CLEAR 8'hff
`define SEPP_PTR_LOCK 8'h00
`define SEPP_ADDR_ALL 8'hff
`define SEPP_WRITE_MS 10
`define SEPP_CLK_MHZ 125
`endif

// *** verilog/sepp_buf.v ***
/*
 contents: two-entry valid/ready buffer for output words.
 assumes: single clock domain, synchronous to CLK with async high reset.
*/
`timescale 1ns/1ns
module sepp_buf #(
   parameter W = 17
)
(
   // clock and reset
   input wire clk,
   input wire rst,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem [0:1];
   reg wp;
   reg rp;
   reg [1:0] cnt;
   wire push;
   wire pop;
   assign in_ready = (cnt != 2'h2);
   assign out_valid = (cnt != 2'h0);
   assign out_data = mem[rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wp <= 1'b0;
         rp <= 1'b0;
         cnt <= 2'h0;
         mem[0] <= {W{1'b0}};
         mem[1] <= {W{1'b0}};
      end
      else
      begin
         if (push)
         begin
            mem[wp] <= in_data;
            wp <= ~wp;
         end
         if (pop)
            rp <= ~rp;
         cnt <= cnt + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule // sepp_buf

// *** verilog/sepp_eeprom.v ***
/*
 contents: serial eeprom core with memory pointer write protection.
 assumes: serial pins are asynchronous to CLK; serial clock is much slower
 than CLK (1 MHz max against 125 MHz); RST stands in for power-up.
*/
`timescale 1ns/1ns
`include "sepp_consts.vh"
module sepp_eeprom #(
   parameter ADDR_W = 8,
   parameter WORDS = 256,
   parameter WRITE_CYCLES = (`SEPP_WRITE_MS * `SEPP_CLK_MHZ * 1000)
)
(
   // clock and reset
   input wire CLK,
   input wire RST,
   // serial pins
   input wire CHIP_SEL,
   input wire SERIAL_CLK,
   input wire SERIAL_IN,
   input wire PROGRAM_EN_PIN,
   input wire PROTECT_EN_PIN,
   output reg SERIAL_OUT,
   output reg SERIAL_OUT_EN,
   // state seen outside
   output reg WRITE_ENABLED,
   output reg BUSY,
   output reg [7:0] POINTER,
   output reg POINTER_LOCKED
);
   localparam S_IDLE = 3'h0;
   localparam S_HDR = 3'h1;
   localparam S_DATA = 3'h2;
   localparam S_READ = 3'h3;
   localparam S_WAIT = 3'h4;
   localparam S_PROG = 3'h5;
   localparam S_DONE = 3'h6;
   reg [15:0] mem [0:WORDS-1];
   reg [1:0] cs_s;
   reg [1:0] sk_s;
   reg [1:0] di_s;
   reg [1:0] pe_s;
   reg [1:0] pre_s;
   reg sk_d;
   reg [2:0] state;
   reg [4:0] bitcnt;
   reg [10:0] hdr;
   reg [15:0] data;
   reg pre_at;
   reg pe_at;
   reg [7:0] addr;
   reg [16:0] shreg;
   reg [4:0] outcnt;
   reg ptr_read;
   reg ptr_armed;
   reg is_wall;
   reg [31:0] timer;
   reg [7:0] fill;
   reg ptr_go;
   integer k;
   wire cs;
   wire sk_rise;
   wire di;
   wire [1:0] op;
   wire [7:0] haddr;
   wire buf_ready;
   wire buf_valid;
   wire [16:0] buf_data;
   reg buf_push;
   reg [16:0] buf_word;
   reg buf_pop;
   reg ptr_cleared;

   // top address bit falls away for the smaller array
   localparam integer ADDR_MASK = WORDS - 1;
   function [7:0] mask_addr;
      input [7:0] a;
      begin
         mask_addr = a & ADDR_MASK[7:0];
      end
   endfunction

   assign cs = cs_s[1];
   assign di = di_s[1];
   assign sk_rise = sk_s[1] && !sk_d;
   assign op = hdr[9:8];
   assign haddr = hdr[7:0];

   sepp_buf #(
      .W(17)
   )
   u_buf (
      .clk(CLK),
      .rst(RST),
      .in_valid(buf_push),
      .in_ready(buf_ready),
      .in_data(buf_word),
      .out_valid(buf_valid),
      .out_ready(buf_pop),
      .out_data(buf_data)
   );

   // two-stage synchronisers; sk_d only feeds the edge detector
   always @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         cs_s <= 2'h0;
         sk_s <= 2'h0;
         di_s <= 2'h0;
         pe_s <= 2'h0;
         pre_s <= 2'h0;
         sk_d <= 1'b0;
      end
      else
      begin
         cs_s <= {cs_s[0], CHIP_SEL};
         sk_s <= {sk_s[0], SERIAL_CLK};
         di_s <= {di_s[0], SERIAL_IN};
         pe_s <= {pe_s[0], PROGRAM_EN_PIN};
         pre_s <= {pre_s[0], PROTECT_EN_PIN};
         sk_d <= sk_s[1];
      end
   end

   // refill the read buffer with the next word while streaming
   always @*
   begin
      buf_push = 1'b0;
      buf_word = {1'b0, mem[mask_addr(addr)]};
      if (state == S_READ && !ptr_read && fill != 8'h00)
         buf_push = 1'b1;
   end

   always @*
   begin
      buf_pop = 1'b0;
      if (state == S_READ && sk_rise && cs && outcnt == 5'h00 && buf_valid)
         buf_pop = 1'b1;
      else if (state != S_READ && buf_valid)
         buf_pop = 1'b1; // a word prefetched by the last read must not leak
   end

   always @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         state <= S_IDLE;
         bitcnt <= 5'h00;
         hdr <= 11'h000;
         data <= 16'h0000;
         pre_at <= 1'b0;
         pe_at <= 1'b0;
         addr <= 8'h00;
         shreg <= 17'h00000;
         outcnt <= 5'h00;
         ptr_read <= 1'b0;
         ptr_armed <= 1'b0;
         ptr_go <= 1'b0;
         is_wall <= 1'b0;
         timer <= 32'h0;
         fill <= 8'h00;
         ptr_cleared <= 1'b1;
         WRITE_ENABLED <= 1'b0;
         BUSY <= 1'b0;
         POINTER <= `SEPP_PTR_CLEAR;
         POINTER_LOCKED <= 1'b0;
         SERIAL_OUT <= 1'b0;
         SERIAL_OUT_EN <= 1'b0;
      end
      else
      begin
         SERIAL_OUT_EN <= 1'b0;
         case (state)
            S_IDLE:
            begin
               bitcnt <= 5'h00;
               if (cs && sk_rise && di)
                  state <= S_HDR; // start bit
            end
            S_HDR:
            begin
               if (!cs)
                  state <= S_IDLE;
               else if (sk_rise)
               begin
                  hdr <= {hdr[9:0], di};
                  bitcnt <= bitcnt + 5'h01;
                  pre_at <= pre_s[1];
                  pe_at <= pe_s[1];
                  if (bitcnt == `SEPP_HDR_BITS - 5'h02)
                  begin
                     bitcnt <= 5'h00;
                     state <= S_WAIT;
                     ptr_go <= ptr_armed;
                     ptr_armed <= 1'b0;
                     if ({hdr[8:0], di} >> 8 == {3'h0, `SEPP_OP_READ})
                     begin
                        state <= S_READ;
                        ptr_read <= pre_s[1];
                        addr <= mask_addr({hdr[6:0], di});
                        fill <= pre_s[1] ? 8'h00 : 8'h01;
                        SERIAL_OUT <= 1'b0;
                        shreg <= pre_s[1] ? {POINTER, 9'h000} : 17'h00000;
                        outcnt <= pre_s[1] ? `SEPP_PTR_BITS : 5'h00;
                     end
                     else if (!pre_s[1] && ({hdr[8:0], di} >> 8 == 10'h001
                              || {hdr[8:0], di} >> 6 == {2'h0, `SEPP_EXT_WALL}))
                        state <= S_DATA;
                  end
               end
            end
            S_DATA:
            begin
               if (!cs)
                  state <= S_IDLE;
               else if (sk_rise)
               begin
                  data <= {data[14:0], di};
                  bitcnt <= bitcnt + 5'h01;
                  if (bitcnt == `SEPP_DATA_BITS - 5'h01)
                     state <= S_WAIT;
               end
            end
            S_READ:
            begin
               if (!cs)
               begin
                  state <= S_IDLE;
                  fill <= 8'h00;
               end
               else
               begin
                  if (buf_push)
                  begin
                     fill <= 8'h00;
                     addr <= mask_addr(addr + 8'h01);
                  end
                  if (sk_rise)
                  begin
                     if (outcnt != 5'h00)
                     begin
                        SERIAL_OUT <= shreg[16];
                        shreg <= {shreg[15:0], 1'b0};
                        outcnt <= outcnt - 5'h01;
                     end
                     else if (!ptr_read && buf_valid)
                     begin
                        SERIAL_OUT <= buf_data[15];
                        shreg <= {buf_data[14:0], 2'h0};
                        outcnt <= `SEPP_DATA_BITS - 5'h01;
                        fill <= 8'h01;
                     end
                  end
                  SERIAL_OUT_EN <= 1'b1;
               end
            end
            S_WAIT:
            begin
               // commands take effect on deselect; pins sampled at load
               if (!cs)
               begin
                  state <= S_IDLE;
                  if (pre_at && pe_at && !POINTER_LOCKED)
                  begin
                     if (op == `SEPP_OP_EXT && haddr[7:6] == `SEPP_EXT_EN && WRITE_ENABLED)
                        ptr_armed <= 1'b1;
                     if (ptr_go && op == `SEPP_OP_CLEAR && haddr == `SEPP_PTR_CLEAR)
                     begin
                        POINTER <= `SEPP_PTR_CLEAR;
                        ptr_cleared <= 1'b1;
                     end
                     else if (ptr_go && op == `SEPP_OP_WRITE)
                     begin
                        POINTER <= mask_addr(haddr);
                        ptr_cleared <= 1'b0;
                     end
                     else if (ptr_go && op == `SEPP_OP_EXT && haddr == `SEPP_PTR_LOCK)
                        POINTER_LOCKED <= 1'b1;
                  end
                  if (!pre_at && op == `SEPP_OP_EXT)
                  begin
                     if (haddr[7:6] == `SEPP_EXT_EN && pe_at)
                        WRITE_ENABLED <= 1'b1;
                     if (haddr[7:6] == `SEPP_EXT_DIS)
                        WRITE_ENABLED <= 1'b0;
                  end
                  if (!pre_at && pe_at && WRITE_ENABLED && bitcnt == `SEPP_DATA_BITS)
                  begin
                     is_wall <= (op == `SEPP_OP_EXT);
                     addr <= mask_addr(haddr);
                     if (op == `SEPP_OP_EXT && ptr_cleared)
                     begin
                        state <= S_PROG;
                        BUSY <= 1'b1;
                        timer <= 32'h0;
                     end
                     else if (op == `SEPP_OP_WRITE && (ptr_cleared
                              || mask_addr(haddr) < POINTER))
                     begin
                        state <= S_PROG;
                        BUSY <= 1'b1;
                        timer <= 32'h0;
                     end
                  end
               end
            end
            S_PROG:
            begin
               timer <= timer + 32'h1;
               if (cs)
               begin
                  SERIAL_OUT_EN <= 1'b1;
                  SERIAL_OUT <= 1'b0;
               end
               if (timer >= WRITE_CYCLES - 1)
               begin
                  if (is_wall)
                     for (k = 0; k < WORDS; k = k + 1)
                        mem[k] <= data;
                  else
                     mem[addr] <= data;
                  BUSY <= 1'b0;
                  state <= S_DONE;
               end
            end
            S_DONE:
            begin
               // ready stays on the pin until the host deselects
               if (cs)
               begin
                  SERIAL_OUT_EN <= 1'b1;
                  SERIAL_OUT <= 1'b1;
               end
               else
                  state <= S_IDLE;
            end
            default:
               state <= S_IDLE;
         endcase
      end
   end
endmodule // sepp_eeprom

// *** verif/sepp_eeprom_asserts.sv ***
/*
 holds: timing checks on the protected eeprom's ports.
 assumes: bound to sepp_eeprom; one clock domain, RST async high.
*/
`timescale 1ns/1ns
module sepp_eeprom_asserts #(
   parameter WRITE_CYCLES = 1250000
)
(
   // clock and reset
   input wire CLK,
   input wire RST,
   // serial pins
   input wire CHIP_SEL,
   input wire SERIAL_OUT,
   input wire SERIAL_OUT_EN,
   // device state
   input wire WRITE_ENABLED,
   input wire BUSY,
   input wire [7:0] POINTER,
   input wire POINTER_LOCKED
);
   integer busy_len;

   // cycles of programming so far, checked when busy ends
   always @(posedge CLK or posedge RST)
      if (RST)
         busy_len <= 0;
      else
         busy_len <= BUSY ? busy_len + 1 : 0;

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   busy_cause_a: assert property ($rose(BUSY) |-> !CHIP_SEL)
      else $error("programming began while selected");
   write_gate_a: assert property ($rose(BUSY) |-> WRITE_ENABLED)
      else $error("programming began while writes disabled");
   busy_hold_a: assert property ($rose(BUSY) |-> ##1 BUSY [*8])
      else $error("programming ended too soon");
   busy_len_a: assert property ($fell(BUSY) |-> busy_len == WRITE_CYCLES)
      else $error("programming length wrong");
   out_release_a: assert property (!CHIP_SEL [*5] |-> !SERIAL_OUT_EN)
      else $error("serial out driven while deselected");
   status_low_a: assert property (BUSY && SERIAL_OUT_EN |-> !SERIAL_OUT)
      else $error("busy not shown low");
   status_drive_a: assert property (CHIP_SEL [*5] ##0 BUSY |-> SERIAL_OUT_EN)
      else $error("status not driven while selected");
   ready_high_a: assert property (CHIP_SEL [*5] ##1 $fell(BUSY)
      |-> ##[0:2] SERIAL_OUT_EN && SERIAL_OUT)
      else $error("ready not shown high");
   lock_freeze_a: assert property (POINTER_LOCKED |=> POINTER_LOCKED && $stable(POINTER))
      else $error("locked pointer moved");
   ptr_gate_a: assert property ($changed(POINTER) |-> WRITE_ENABLED)
      else $error("pointer changed while writes disabled");

   cover property ($rose(BUSY));
   cover property ($rose(POINTER_LOCKED));
   cover property (SERIAL_OUT_EN && !BUSY);
endmodule // sepp_eeprom_asserts

bind sepp_eeprom sepp_eeprom_asserts #(.WRITE_CYCLES(WRITE_CYCLES)) chk (
   .CLK(CLK), .RST(RST), .CHIP_SEL(CHIP_SEL), .SERIAL_OUT(SERIAL_OUT),
   .SERIAL_OUT_EN(SERIAL_OUT_EN), .WRITE_ENABLED(WRITE_ENABLED), .BUSY(BUSY),
   .POINTER(POINTER), .POINTER_LOCKED(POINTER_LOCKED));

// *** verif/sepp_host.sv ***
/*
 holds: serial host model driving the eeprom pins.
 assumes: clk is the bench clock; a serial period is 8 clk.
*/
`timescale 1ns/1ns
module sepp_host (
   // bench clock
   input wire clk,
   // serial pins
   input wire serial_out,
   output reg chip_sel,
   output reg serial_clk,
   output reg serial_in,
   output reg program_en_pin,
   output reg protect_en_pin
);
   initial
   begin
      chip_sel = 1'b0;
      serial_clk = 1'b0;
      serial_in = 1'b0;
      program_en_pin = 1'b0;
      protect_en_pin = 1'b0;
   end

   // half a serial period; changes land just after the edge
   task half;
   begin
      repeat (4) @(posedge clk);
      #1;
   end
   endtask

   // enables held through the whole load
   task cmd(input [26:0] v, input integer n, input pe, input pre);
      integer i;
   begin
      program_en_pin = pe;
      protect_en_pin = pre;
      chip_sel = 1'b1;
      for (i = n - 1; i >= 0; i = i - 1)
      begin
         serial_in = v[i];
         half;
         serial_clk = 1'b1;
         half;
         serial_clk = 1'b0;
      end
      serial_in = ~serial_in;
      half;
   end
   endtask

   // sampled just before the next rise, where the bit has settled
   task rd(input integer n, output [31:0] v);
      integer i;
   begin
      v = 32'h0;
      for (i = 0; i < n; i = i + 1)
      begin
         serial_clk = 1'b1;
         half;
         serial_clk = 0;
         half;
         v = {v[30:0], serial_out};
      end
   end
   endtask

   // deselect before the next rise; clock stands still meanwhile
   task drop;
   begin
      chip_sel = 1'b0;
      serial_in = ~serial_in;
      repeat (32) @(posedge clk);
      #1;
   end
   endtask

   task sel;
   begin
      chip_sel = 1'b1;
      repeat (8) @(posedge clk);
      #1;
   end
   endtask
endmodule // sepp_host

// *** verif/sepp_eeprom_tb.sv ***
/*
 holds: self-checking bench of the protected eeprom.
 assumes: sepp_host drives the pins; short programming time.
*/
`timescale 1ns/1ns
module sepp_eeprom_tb;
   localparam WCYC = 100;
   localparam [10:0] erase_write_enable_cmd = 11'h4c0;
   localparam [10:0] erase_write_disable_cmd = 11'h400;
   localparam [10:0] pointer_enable_cmd = 11'h4c0;
   localparam [10:0] pointer_clear_cmd = 11'h7ff;
   localparam [10:0] pointer_lock_cmd = 11'h400;
   localparam [10:0] write_all_cmd = 11'h440;
   reg clk = 1'b0;
   reg rst = 1'b1;
   wire cs, sk, di, pe, pre, dout, dout_en, wr_en, busy, locked;
   wire [7:0] pointer;
   // released line floats; nothing pulls it
   wire so_line = dout_en ? dout : 1'bz;
   integer num_errors = 0;
   integer compares = 0;
   reg [31:0] v;

   always #4 clk = ~clk;

   sepp_host host (.clk(clk), .serial_out(so_line), .chip_sel(cs), .serial_clk(sk),
      .serial_in(di), .program_en_pin(pe), .protect_en_pin(pre));

   sepp_eeprom #(.WRITE_CYCLES(WCYC)) uut (.CLK(clk), .RST(rst), .CHIP_SEL(cs),
      .SERIAL_CLK(sk), .SERIAL_IN(di), .PROGRAM_EN_PIN(pe), .PROTECT_EN_PIN(pre),
      .SERIAL_OUT(dout), .SERIAL_OUT_EN(dout_en), .WRITE_ENABLED(wr_en), .BUSY(busy),
      .POINTER(pointer), .POINTER_LOCKED(locked));

   task chk(input [95:0] what, input [31:0] seen, input [31:0] exp);
   begin
      compares = compares + 1;
      if (seen !== exp)
      begin
         num_errors = num_errors + 1;
         $display("BAD %0s expected %h seen %h", what, exp, seen);
      end
   end
   endtask

   task print_verdict;
   begin
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask

   task idle;
      integer i;
   begin
      for (i = 0; i < 300 && busy !== 1'b0; i = i + 1)
         @(posedge clk);
      #1;
      if (busy !== 1'b0)
      begin
         num_errors = num_errors + 1;
         print_verdict;
      end
   end
   endtask

   task op(input [10:0] h, input p, input r);
   begin
      host.cmd({16'h0, h}, 11, p, r);
      host.drop;
      idle;
   end
   endtask

   // accepted frames are polled for status while selected again
   task prog(input [26:0] f, input ok);
   begin
      host.cmd(f, 27, 1'b1, 1'b0);
      host.drop;
      chk("busy", busy, ok);
      if (ok)
      begin
         host.sel;
         chk("status", {dout_en, so_line}, 2'b10);
         idle;
         host.sel;
         chk("ready", {dout_en, so_line}, 2'b11);
         host.drop;
      end
   end
   endtask

   task rdchk(input [10:0] h, input r, input integer n, input [31:0] exp);
   begin
      host.cmd({16'h0, h}, 11, 1'b0, r);
      chk("dummy", {dout_en, so_line}, 2'b10);
      host.rd(n, v);
      chk("read", v, exp);
      host.drop;
      chk("release", dout_en, 1'b0);
   end
   endtask

   task t_reset;
   begin
      chk("state", {wr_en, busy, locked, dout_en, pointer}, 12'h0ff);
      $display("reset test done");
   end
   endtask

   task t_rw;
   begin
      prog({11'h505, 16'ha5c3}, 1'b0);
      op(erase_write_enable_cmd, 1'b1, 1'b0);
      chk("wr_en", wr_en, 1'b1);
      prog({11'h505, 16'ha5c3}, 1'b1);
      prog({11'h506, 16'h5a3c}, 1'b1);
      op(erase_write_disable_cmd, 1'b0, 1'b0);
      chk("wr_en", wr_en, 1'b0);
      rdchk(11'h605, 1'b0, 32, 32'ha5c35a3c);
      $display("read write test done");
   end
   endtask

   task t_ptr;
   begin
      op(erase_write_enable_cmd, 1'b1, 1'b0);
      op(pointer_enable_cmd, 1'b1, 1'b1);
      op(11'h510, 1'b1, 1'b1);
      chk("pointer", pointer, 8'h10);
      prog({11'h510, 16'h1111}, 1'b0);
      prog({11'h50f, 16'h2222}, 1'b1);
      prog({write_all_cmd, 16'hffff}, 1'b0);
      rdchk(11'h600, 1'b1, 8, 32'h10);
      op(11'h520, 1'b1, 1'b1);
      chk("pointer", pointer, 8'h10);
      $display("pointer test done");
   end
   endtask

   task t_clear;
   begin
      op(pointer_enable_cmd, 1'b1, 1'b1);
      op(pointer_clear_cmd, 1'b1, 1'b1);
      chk("pointer", pointer, 8'hff);
      prog({write_all_cmd, 16'h1357}, 1'b1);
      rdchk(11'h67f, 1'b0, 16, 32'h1357);
      op(erase_write_disable_cmd, 1'b0, 1'b0);
      op(pointer_enable_cmd, 1'b1, 1'b1);
      op(11'h540, 1'b1, 1'b1);
      chk("pointer", pointer, 8'hff);
      $display("clear test done");
   end
   endtask

   task t_lock;
   begin
      op(erase_write_enable_cmd, 1'b1, 1'b0);
      op(pointer_enable_cmd, 1'b1, 1'b1);
      op(11'h580, 1'b1, 1'b1);
      op(pointer_enable_cmd, 1'b1, 1'b1);
      op(pointer_lock_cmd, 1'b1, 1'b1);
      chk("locked", {locked, pointer}, 9'h180);
      op(pointer_enable_cmd, 1'b1, 1'b1);
      op(pointer_clear_cmd, 1'b1, 1'b1);
      chk("pointer", pointer, 8'h80);
      $display("lock test done");
   end
   endtask

   initial
   begin
      repeat (12) @(posedge clk);
      #1;
      rst = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      t_reset;
      t_rw;
      t_ptr;
      t_clear;
      t_lock;
      print_verdict;
   end
endmodule // sepp_eeprom_tb
